// File: verilog/serial_port_defs.vh
// Purpose: constants for the converter serial output port
// Assumes: one clock, 200 MHz
// Notes: offsets, field positions, reset values and timing counts
// Behaviour
// - filter-type bit: 0 wideband, 1 sinc5
// - pin mode: one filter pin for all
// - register mode: filter chosen per channel
// - saturated bit set on clip, no wrap
// - channel id bits carry binary channel number
// - device masters clock, strobe and data
// - strobe one bit clock before msb
// - strobe fall starts words, header first
// - format 00 per lane, 01 two lanes
// - modes 0xa div4, 0x8/0x4 undivided clock; the code runs 0x8/0x4 at clk/2
// - lanes held low after words end
// - one-shot by modes 0xc-0xf or bit 4
// - sync rise resets filters, strobe low
// - one-shot strobe is active-high frame
// - settle time elapses before one-shot output
// - all channels sent, bit 6 flags unsettled
// - one-shot idles until next sync
// - chain uses lanes seven/eight as inputs
// - chain shifts upstream data on rising edge
// - 32-bit word, header then msb-first result
// - format 1x all on first lane
`ifndef SERIAL_PORT_DEFS_VH
`define SERIAL_PORT_DEFS_VH
// ----------------------------------------
// register map
// ----------------------------------------
`define REG_DATA_CTRL_ADDR 8'h06
`define REG_DATA_CTRL_RESET 8'h00
`define CTRL_ONE_SHOT_BIT 4
// ----------------------------------------
// header field positions
// ----------------------------------------
`define HDR_ERROR_BIT 7
`define HDR_UNSETTLED_BIT 6
`define HDR_REPEAT_BIT 5
`define HDR_FILTER_BIT 4
`define HDR_SAT_BIT 3
// ----------------------------------------
// pin mode codes and format codes
// ----------------------------------------
`define MODE_FAST_DIV4 4'ha
`define MODE_FAST_DIV1 4'h8
`define MODE_MEDIAN_DIV1 4'h4
`define FMT_PER_LANE 2'b00
`define FMT_TWO_LANES 2'b01
// ----------------------------------------
// timing
// ----------------------------------------
`define WORD_BITS 32
`define CLK_PERIOD_NS 5
`define SETTLE_TIME_NS 1000
`define SETTLE_CYCLES ((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: verilog/word_buffer.v
// Purpose: two-entry valid/ready buffer for channel word sets
// Assumes: synchronous inputs, one clock
// Notes: full and empty are exact; ce low freezes everything
`timescale 1ns/10ps
module word_buffer #(
  parameter WIDTH = 256
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  input wire ce,
  // fill side
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  // drain side
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg [WIDTH-1:0] mem_q [0:1]; // two slots
  reg wr_q; // write index
  reg rd_q; // read index
  reg [1:0] cnt_q; // occupancy
  wire push;
  wire pop;
  assign in_ready = (cnt_q != 2'd2); // honest full
  assign out_valid = (cnt_q != 2'd0); // honest empty
  assign out_data = mem_q[rd_q];
  assign push = ce & in_valid & in_ready;
  assign pop = ce & out_valid & out_ready;
  // pointer and count update
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      cnt_q <= 2'd0;
    end else begin
      if (push) wr_q <= ~wr_q;
      if (pop) rd_q <= ~rd_q;
      if (push & ~pop) cnt_q <= cnt_q + 2'd1;
      else if (pop & ~push) cnt_q <= cnt_q - 2'd1;
    end
  end
  // data slots, no reset needed on payload
  always @(posedge clk) begin
    if (push) mem_q[wr_q] <= in_data;
  end
endmodule // word_buffer

// File: verilog/serial_output_port.v
// Purpose: serial output framer of an eight-channel sigma-delta converter
// Assumes: conversion results arrive as one word set per output_word_rate tick
// Notes: bit clock derived from clk; format latched once after reset
`timescale 1ns/10ps
`include "serial_port_defs.vh"
module serial_output_port #(
  parameter NCH = 8,
  parameter SETTLE_CYCLES = `SETTLE_CYCLES
) (
  // clock, reset, enable
  input wire clk,
  input wire rstn,
  input wire ce,
  // pin configuration
  input wire pin_ctrl_mode,
  input wire filter_sel_pin,
  input wire [3:0] pin_mode,
  input wire [1:0] lane_format_pins,
  input wire chain_enable,
  // register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire [NCH-1:0] reg_filter_sel,
  // conversion results from the filters
  input wire sample_valid,
  output wire sample_ready,
  input wire [NCH*24-1:0] sample_data,
  input wire [NCH-1:0] sample_clip,
  input wire [NCH-1:0] sample_settled,
  output reg filter_reset,
  // sync from host
  input wire sync_in,
  // serial link
  output reg serial_bit_clock,
  output reg frame_strobe_n,
  output reg [NCH-1:0] serial_out_lanes,
  input wire chain_in_lane_first,
  input wire chain_in_lane_second
);
  // ----------------------------------------
  // state codes
  // ----------------------------------------
  localparam ST_IDLE = 2'd0;
  localparam ST_LEAD = 2'd1;
  localparam ST_SHIFT = 2'd2;
  localparam ST_SETTLE = 2'd3;
  localparam [15:0] SETTLE_N = SETTLE_CYCLES;

  // ----------------------------------------
  // control register
  // ----------------------------------------
  reg [7:0] ctrl_q; // conversion_data_control
  wire one_shot;
  wire [1:0] fmt_eff;
  reg [1:0] fmt_q; // format captured after reset
  reg fmt_done_q;
  // register write and read-back
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= `REG_DATA_CTRL_RESET;
      reg_rdata <= 8'h00;
    end else if (ce) begin
      if (reg_wr && reg_addr == `REG_DATA_CTRL_ADDR) ctrl_q <= reg_wdata;
      if (reg_rd) reg_rdata <= (reg_addr == `REG_DATA_CTRL_ADDR) ? ctrl_q : 8'h00;
    end
  end
  // format pins read once; they are meant to be hardwired
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fmt_q <= 2'b00;
      fmt_done_q <= 1'b0;
    end else if (ce && !fmt_done_q) begin
      fmt_q <= lane_format_pins;
      fmt_done_q <= 1'b1;
    end
  end
  assign fmt_eff = fmt_q;
  // one-shot from pin code or register bit
  assign one_shot = pin_ctrl_mode ? (pin_mode[3:2] == 2'b11)
                                  : ctrl_q[`CTRL_ONE_SHOT_BIT];

  // ----------------------------------------
  // bit clock divider
  // ----------------------------------------
  // only 0xa divides by four; other codes run at clk/2, the fastest toggle
  wire div4;
  reg [1:0] div_q;
  wire bit_tick; // clk edge on which the bit clock falls
  wire rise_tick; // clk edge on which the bit clock rises
  assign div4 = pin_ctrl_mode && (pin_mode == `MODE_FAST_DIV4);
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_q <= 2'd0;
      serial_bit_clock <= 1'b0;
    end else if (ce) begin
      div_q <= div4 ? div_q + 2'd1 : {1'b0, ~div_q[0]};
      serial_bit_clock <= div4 ? div_q[1] : div_q[0];
    end
  end
  // launch on falling edge of the bit clock, so the host has half a bit of margin
  assign bit_tick = div4 ? (div_q == 2'd0) : ~div_q[0];
  assign rise_tick = div4 ? (div_q == 2'd2) : div_q[0];

  // ----------------------------------------
  // word set assembly
  // ----------------------------------------
  reg [NCH*32-1:0] words; // header plus result per channel
  integer i;
  integer j; // lane loop of the clocked process
  // build the 32-bit word per channel; channel 0 sits at the top of the
  // image so that shared lanes send channels in ascending order
  always @* begin
    words = {NCH*32{1'b0}};
    for (i = 0; i < NCH; i = i + 1) begin
      words[(NCH-1-i)*32+31] = 1'b0; // no error source here
      words[(NCH-1-i)*32+30] = ~sample_settled[i];
      words[(NCH-1-i)*32+29] = 1'b0; // single rate, no repeat
      words[(NCH-1-i)*32+28] = pin_ctrl_mode ? filter_sel_pin
                                             : reg_filter_sel[i];
      words[(NCH-1-i)*32+27] = sample_clip[i];
      words[(NCH-1-i)*32+24 +: 3] = i[2:0];
      words[(NCH-1-i)*32 +: 24] = sample_data[i*24 +: 24];
    end
  end

  // ----------------------------------------
  // buffer between filters and shifter
  // ----------------------------------------
  wire buf_valid;
  reg buf_ready;
  wire [NCH*32-1:0] buf_data;
  reg gate_q; // one-shot: accept sets only when armed
  wire in_valid_g;
  wire in_ready_b;
  assign in_valid_g = sample_valid & (~one_shot | gate_q);
  // drop unrequested sets in one-shot so filters do not stall while disarmed
  assign sample_ready = in_ready_b | (one_shot & ~gate_q);
  word_buffer #(.WIDTH(NCH*32)) u_buf (
    .clk(clk),
    .rstn(rstn),
    .ce(ce),
    .in_valid(in_valid_g),
    .in_ready(in_ready_b),
    .in_data(words),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );

  // ----------------------------------------
  // framer state machine
  // ----------------------------------------
  reg [1:0] st_q;
  reg [NCH*32-1:0] sh_q; // shift image
  reg [7:0] bit_cnt_q; // bits left in the frame, minus one
  reg [15:0] settle_q;
  reg sync_d_q; // previous sync level
  reg [1:0] chain_q; // sampled chain inputs
  reg [7:0] frame_bits; // bits per lane for the format, minus one
  wire sync_rise;
  assign sync_rise = sync_in & ~sync_d_q; // sync is synchronous to clk
  // bits per lane by format
  always @* begin
    if (fmt_eff == `FMT_PER_LANE) frame_bits = 8'd31; // 32 bits
    else if (fmt_eff == `FMT_TWO_LANES) frame_bits = 8'd127; // 128 bits
    else frame_bits = 8'd255; // 256 bits, counter holds 255 down to 0
  end
  // pop a set when the shifter starts it
  always @* begin
    buf_ready = 1'b0;
    if (st_q == ST_IDLE && bit_tick && !(one_shot && !gate_q)) buf_ready = 1'b1;
  end
  // sequencing, strobe, lanes
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= ST_IDLE;
      sh_q <= {NCH*32{1'b0}};
      bit_cnt_q <= 8'd0;
      settle_q <= 16'd0;
      sync_d_q <= 1'b0;
      gate_q <= 1'b0;
      chain_q <= 2'b00;
      filter_reset <= 1'b0;
      frame_strobe_n <= 1'b1;
      serial_out_lanes <= {NCH{1'b0}};
    end else if (ce) begin
      sync_d_q <= sync_in;
      filter_reset <= 1'b0;
      if (one_shot && sync_rise) begin
        filter_reset <= 1'b1;
        frame_strobe_n <= 1'b0;
        gate_q <= 1'b0;
        settle_q <= SETTLE_N;
        st_q <= ST_SETTLE;
        serial_out_lanes <= {NCH{1'b0}};
      end else begin
        case (st_q)
          ST_IDLE: begin
            if (buf_valid && buf_ready) begin
              sh_q <= buf_data;
              st_q <= ST_LEAD;
              bit_cnt_q <= frame_bits;
              // standard: strobe low one bit period ahead of the msb
              if (!one_shot) frame_strobe_n <= 1'b0;
            end else if (bit_tick && one_shot) begin
              frame_strobe_n <= 1'b0; // frame ends after the last bit stood
            end
          end
          ST_LEAD, ST_SHIFT: begin
            if (bit_tick) begin
              st_q <= ST_SHIFT;
              // strobe rises with the msb: end of low pulse or start of high frame
              if (st_q == ST_LEAD) frame_strobe_n <= 1'b1;
              if (chain_enable) begin
                // chain mode: lanes 0/1 out, upstream data shifted behind
                serial_out_lanes <= {{NCH-2{1'b0}}, sh_q[NCH*16-1], sh_q[NCH*32-1]};
                sh_q <= {sh_q[NCH*32-2:NCH*16], chain_q[0],
                         sh_q[NCH*16-2:0], chain_q[1]};
              end else if (fmt_eff == `FMT_PER_LANE) begin
                for (j = 0; j < NCH; j = j + 1)
                  serial_out_lanes[j] <= sh_q[(NCH-1-j)*32+31];
                sh_q <= sh_q << 1;
              end else if (fmt_eff == `FMT_TWO_LANES) begin
                // ch0..3 on lane 0, ch4..7 on lane 1, ascending
                serial_out_lanes <= {{NCH-2{1'b0}}, sh_q[NCH*16-1], sh_q[NCH*32-1]};
                sh_q <= sh_q << 1;
              end else begin
                serial_out_lanes <= {{NCH-1{1'b0}}, sh_q[NCH*32-1]};
                sh_q <= sh_q << 1;
              end
              if (bit_cnt_q == 8'd0) begin
                st_q <= ST_IDLE;
                if (one_shot) gate_q <= 1'b0; // wait for next sync
              end else begin
                bit_cnt_q <= bit_cnt_q - 8'd1;
              end
            end
          end
          ST_SETTLE: begin
            // filters settle before any output
            if (settle_q == 16'd0) begin
              gate_q <= 1'b1;
              st_q <= ST_IDLE;
            end else begin
              settle_q <= settle_q - 16'd1;
            end
          end
          default: st_q <= ST_IDLE;
        endcase
        // outside a one-shot sync restart, lanes drop only on a bit-clock fall, so the last bit stands a full bit
        if ((st_q == ST_IDLE || st_q == ST_SETTLE) && bit_tick)
          serial_out_lanes <= {NCH{1'b0}};
      end
      // chain inputs taken at the rising bit-clock edge
      if (rise_tick) chain_q <= {chain_in_lane_second, chain_in_lane_first};
    end
  end
endmodule // serial_output_port

// File: test/serial_port_sva.sv
// Purpose: port-level checks for the serial output framer
// Assumes: one clock, async active-low reset, chain and ce held off/on
// Notes: the one-shot bit is mirrored from register writes
`timescale 1ns/10ps
`include "serial_port_defs.vh"
module serial_port_sva #(
  parameter NCH = 8,
  parameter SETTLE_CYCLES = 5
) (
  // clock, reset, setup
  input wire clk,
  input wire rstn,
  input wire pin_ctrl_mode,
  input wire [3:0] pin_mode,
  input wire [1:0] lane_format_pins,
  // register port
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata,
  // link
  input wire filter_reset,
  input wire serial_bit_clock,
  input wire frame_strobe_n,
  input wire [NCH-1:0] serial_out_lanes
);
  // ----
  // helpers
  // ----
  reg os_bit_q; // last written one-shot bit
  reg sent_q; // a one-shot frame already went out
  reg [15:0] since_q; // cycles since filter reset, saturating
  wire os = pin_ctrl_mode ? (pin_mode[3:2] == 2'b11) : os_bit_q;
  wire div2 = pin_ctrl_mode && (pin_mode != 4'ha);
  // ce is not watched, so a frozen design would look stalled here
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      os_bit_q <= 1'b0;
      sent_q <= 1'b0;
      since_q <= 16'h0000;
    end else begin
      if (reg_wr && reg_addr == `REG_DATA_CTRL_ADDR)
        os_bit_q <= reg_wdata[`CTRL_ONE_SHOT_BIT];
      sent_q <= !filter_reset && (sent_q || (os && $rose(frame_strobe_n)));
      if (filter_reset)
        since_q <= 16'h0000;
      else if (since_q != 16'hffff)
        since_q <= since_q + 16'h0001;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_FRES_PULSE: assert property (filter_reset |-> os ##1 !filter_reset)
    else $error("filter reset not a single one-shot pulse");
  AST_DIV4: assert property (pin_ctrl_mode && pin_mode == 4'ha && $rose(serial_bit_clock)
    |=> !$rose(serial_bit_clock) [*3] ##1 $rose(serial_bit_clock)) else $error("div4 period");
  AST_DIV2: assert property (div2 && $rose(serial_bit_clock)
    |=> !serial_bit_clock ##1 $rose(serial_bit_clock)) else $error("div2 period");
  AST_LANE_ON_FALL: assert property ($changed(serial_out_lanes) |-> $fell(serial_bit_clock))
    else $error("lanes moved off the bit clock fall");
  AST_STROBE_START: assert property (div2 && !os && $fell(frame_strobe_n)
    |-> serial_out_lanes == 0 ##1 !frame_strobe_n ##1 frame_strobe_n) else $error("strobe");
  AST_FMT_ONE: assert property (lane_format_pins[1] |-> serial_out_lanes[NCH-1:1] == 0)
    else $error("single-lane format drove another lane");
  AST_FMT_TWO: assert property (lane_format_pins == 2'b01 |-> serial_out_lanes[NCH-1:2] == 0)
    else $error("two-lane format drove another lane");
  AST_SETTLE: assert property (os && $rose(frame_strobe_n) |-> since_q >= SETTLE_CYCLES - 1)
    else $error("one-shot frame before settling");
  AST_ONCE: assert property (os && $rose(frame_strobe_n) |-> !sent_q)
    else $error("second one-shot frame without sync");
  AST_RD_UNMAPPED: assert property (reg_rd && reg_addr != `REG_DATA_CTRL_ADDR
    |-> ##2 reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule // serial_port_sva

// File: test/host_receiver.sv
// Purpose: host receiver model for the serial link
// Assumes: bits launched on the bit clock fall
// Notes: frame_bits of zero idles and clears it
`timescale 1ns/10ps
module host_receiver #(
  parameter NCH = 8
) (
  // link from the converter
  input wire serial_bit_clock,
  input wire frame_strobe_n,
  input wire [NCH-1:0] serial_out_lanes,
  // setup from the bench
  input wire one_shot,
  input wire [8:0] frame_bits,
  output integer frames
);
  // ----
  // capture
  // ----
  logic [255:0] sh [0:NCH-1]; // per-lane shift, last bit lowest
  logic [255:0] fq [$]; // finished frames, NCH lanes each
  integer cnt = 0; // bits of the frame so far
  logic arm = 1'b0; // strobe seen, msb next
  initial frames = 0;
  // sample on the rise, half a bit from the launching fall
  always @(posedge serial_bit_clock) begin
    if (frame_bits == 0) begin
      cnt = 0;
      arm = 1'b0;
    end else if (one_shot ? frame_strobe_n : arm) begin
      for (int i = 0; i < NCH; i++) sh[i] = {sh[i][254:0], serial_out_lanes[i]};
      cnt = cnt + 1;
      if (cnt == frame_bits) begin
        for (int i = 0; i < NCH; i++) fq.push_back(sh[i]);
        frames = frames + 1;
        cnt = 0;
        arm = 1'b0;
      end
    end else arm = !frame_strobe_n;
  end
endmodule // host_receiver

// File: test/testbench.sv
// Purpose: self-checking bench for the serial output framer
// Assumes: 200 MHz clock, inputs driven on the falling edge
// Notes: short settle count; the format is fixed per reset
`timescale 1ns/10ps
`include "serial_port_defs.vh"
`define CHK(nm, e, a) begin compares++; if ((a) !== (e)) begin mismatches++; \
  $display("[FAIL] %s exp %0h got %0h", nm, e, a); end end
module testbench;
  // ----
  // pins and bookkeeping
  // ----
  logic clk, rstn, pin_ctrl_mode, filter_sel_pin, reg_wr, reg_rd, sample_valid, sync_in, os;
  logic ce, chain_a, chain_b; // enable and upstream chain inputs
  logic [3:0] pin_mode;
  logic [1:0] fmt;
  logic [7:0] reg_addr, reg_wdata, reg_filter_sel, sample_clip, sample_settled;
  logic [191:0] sample_data;
  logic [8:0] nbits; // bits per lane per frame, 0 idles the host
  logic saw_full; // buffer refused a set
  logic [207:0] q [$]; // sets in flight: data, clip, settled
  wire [7:0] reg_rdata, lanes;
  wire sample_ready, filter_reset, sbc, fs_n;
  integer mismatches, compares, frames, k, f0;
  logic [3:0] modes [0:3] = '{4'ha, 4'h8, 4'h4, 4'h4};
  logic [1:0] fmts [0:3] = '{2'b00, 2'b01, 2'b11, 2'b10};
  serial_output_port #(.NCH(8), .SETTLE_CYCLES(5)) dut_u (.clk(clk), .rstn(rstn), .ce(ce),
    .pin_ctrl_mode(pin_ctrl_mode), .filter_sel_pin(filter_sel_pin), .pin_mode(pin_mode),
    .lane_format_pins(fmt), .chain_enable(1'b0), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_filter_sel(reg_filter_sel), .sample_valid(sample_valid), .sample_ready(sample_ready),
    .sample_data(sample_data), .sample_clip(sample_clip), .sample_settled(sample_settled),
    .filter_reset(filter_reset), .sync_in(sync_in), .serial_bit_clock(sbc),
    .frame_strobe_n(fs_n), .serial_out_lanes(lanes), .chain_in_lane_first(chain_a),
    .chain_in_lane_second(chain_b));
  host_receiver #(.NCH(8)) host_u (.serial_bit_clock(sbc), .frame_strobe_n(fs_n),
    .serial_out_lanes(lanes), .one_shot(os), .frame_bits(nbits), .frames(frames));
  // expected word of channel c; filter bit follows the control source
  function automatic logic [31:0] word(input logic [207:0] s, input int c);
    logic f;
    f = pin_ctrl_mode ? filter_sel_pin : reg_filter_sel[c];
    return {1'b0, ~s[c], 1'b0, f, s[8+c], c[2:0], s[16+24*c +: 24]};
  endfunction
  // lowest channel of a lane goes first
  function automatic logic [255:0] lane_exp(input logic [207:0] s, input int l, input int n);
    logic [255:0] e;
    e = '0;
    for (int j = 0; j < n; j++) e = {e[223:0], word(s, l * n + j)};
    return e;
  endfunction
  function automatic logic [207:0] rnd_set(input logic corner);
    logic [207:0] s;
    for (int b = 0; b < 208; b += 16) s[b +: 16] = 16'($urandom);
    if (corner) s[63:0] = {24'h800000, 24'h7fffff, 16'hff00}; // full-scale, clipped
    return s;
  endfunction
  task automatic close_out();
    if (mismatches == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic do_reset(input logic pc, input logic [3:0] pm, input logic [1:0] f);
    @(negedge clk);
    {nbits, rstn, pin_ctrl_mode, pin_mode, fmt} = {9'h000, 1'b0, pc, pm, f};
    {filter_sel_pin, reg_filter_sel} = 9'($urandom);
    {chain_a, chain_b} = 2'($urandom);
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
  endtask
  // a read answer stands, so it is looked at two edges on
  task automatic reg_op(input logic w, input logic [7:0] a, input logic [7:0] d);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    @(negedge clk);
    {reg_wr, reg_rd} = 2'b00;
    repeat (2) @(negedge clk);
  endtask
  task automatic push(input logic [207:0] s);
    {sample_data, sample_clip, sample_settled, sample_valid} = {s, 1'b1};
    for (int n = 0; n < 5000 && sample_ready !== 1'b1; n++) begin
      saw_full = 1'b1;
      @(negedge clk);
    end
    if (sample_ready !== 1'b1) begin
      mismatches++;
      close_out();
    end
    @(negedge clk);
    q.push_back(s);
  endtask
  task automatic check_frames(input int want, input int n);
    logic [207:0] s;
    logic [255:0] lv;
    for (int t = 0; t < 40000 && frames < want; t++) @(negedge clk);
    if (frames < want) begin
      mismatches++;
      close_out();
    end
    while (q.size() > 0) begin
      s = q.pop_front();
      for (int l = 0; l < 8; l++) begin
        lv = host_u.fq.pop_front() & ({256{1'b1}} >> (256 - 32 * n));
        if (l < 8 / n) `CHK("lane", lane_exp(s, l, n), lv)
      end
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    {rstn, reg_wr, reg_rd, sample_valid, sync_in, os, reg_addr, reg_wdata} = 22'h0;
    {sample_data, sample_clip, sample_settled} = 208'h0;
    {ce, chain_a, chain_b} = 3'b100;
    {mismatches, compares} = 64'h0;
    void'($urandom(27));
    for (int p = 0; p < 4; p++) begin
      do_reset(p != 3, modes[p], fmts[p]);
      k = fmt == 2'b00 ? 1 : (fmt == 2'b01 ? 4 : 8);
      nbits = 9'(32 * k);
      if (p == 0) begin
        reg_op(0, `REG_DATA_CTRL_ADDR, 8'h00);
        `CHK("ctrl_reset", `REG_DATA_CTRL_RESET, reg_rdata)
        reg_op(1, `REG_DATA_CTRL_ADDR, 8'h10);
        reg_op(1, 8'h07, 8'hff);
        reg_op(0, `REG_DATA_CTRL_ADDR, 8'h00);
        `CHK("ctrl_rw", 8'h10, reg_rdata)
        reg_op(0, 8'h07, 8'h00);
        `CHK("unmapped", 8'h00, reg_rdata)
      end
      {saw_full, f0} = {1'b0, frames};
      for (int i = 0; i < 4; i++) push(rnd_set(i == 0));
      sample_valid = 1'b0;
      `CHK("refused", 1'b1, saw_full)
      check_frames(f0 + 4, k);
      `CHK("drained", 1'b1, sample_ready)
    end
    // one-shot codes, a held set stands for any set taken
    for (int m = 12; m < 16; m++) begin
      do_reset(1'b1, 4'(m), 2'b10);
      {os, f0} = {1'b1, frames};
      q.push_back(rnd_set(1'b0));
      {sample_data, sample_clip, sample_settled, sample_valid} = {q[0], 1'b1};
      sync_in = 1'b1;
      for (int n = 0; n < 8 && filter_reset !== 1'b1; n++) @(negedge clk);
      `CHK("filter_reset", 1'b1, filter_reset)
      sync_in = 1'b0;
      repeat (2) @(negedge clk);
      nbits = 9'd256;
      check_frames(f0 + 1, 8);
      repeat (600) @(negedge clk);
      `CHK("no_repeat", f0 + 1, frames)
      {sample_valid, os} = 2'b00;
    end
    close_out();
  end
endmodule // testbench
bind serial_output_port serial_port_sva #(.NCH(NCH), .SETTLE_CYCLES(SETTLE_CYCLES)) chk_u (
  .clk(clk), .rstn(rstn), .pin_ctrl_mode(pin_ctrl_mode), .pin_mode(pin_mode),
  .lane_format_pins(lane_format_pins), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .filter_reset(filter_reset),
  .serial_bit_clock(serial_bit_clock), .frame_strobe_n(frame_strobe_n),
  .serial_out_lanes(serial_out_lanes));
